// ### core/cal_coeff_bank.sv
// calibration coefficient register bank with axi4-lite slave
// Operation
// - temperature offset coefficient, 16-bit, read/write
// - offset loads factory value, writes replace it
// - current gain coefficient scales current results
// - current gain factory loaded, software may overwrite
// - voltage gain factory loaded, scales voltage results
// - temperature gain coefficient scales temperature results
// - temperature gain loads factory value one edge after each reset release
// - read-only voltage/temperature conversion result register
`timescale 1ns/10ps
`default_nettype none
module cal_coeff_bank
  import cal_coeff_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // factory trim values, static from the fuse block
  input  wire logic [15:0] factory_temp_offset_i,
  input  wire logic [15:0] factory_current_gain_i,
  input  wire logic [15:0] factory_voltage_gain_i,
  input  wire logic [15:0] factory_temp_gain_i,
  // voltage/temperature converter result
  input  wire logic        vt_result_valid_i,
  input  wire logic [15:0] vt_result_i,
  // coefficients to the conversion datapath
  output logic      [15:0] temp_offset_coeff_o,
  output logic      [15:0] current_gain_coeff_o,
  output logic      [15:0] voltage_gain_coeff_o,
  output logic      [15:0] temp_gain_coeff_o,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic      [1:0]  s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic reg_sel_type decode(input logic [31:0] addr);
    case (addr)
      VOLTAGE_TEMP_RESULT_ADDR: decode = SEL_RESULT;
      TEMP_OFFSET_COEFF_ADDR:   decode = SEL_TEMP_OFFSET;
      CURRENT_GAIN_COEFF_ADDR:  decode = SEL_CURRENT_GAIN;
      VOLTAGE_GAIN_COEFF_ADDR:  decode = SEL_VOLTAGE_GAIN;
      TEMP_GAIN_COEFF_ADDR:     decode = SEL_TEMP_GAIN;
      default:                  decode = SEL_NONE;
    endcase
  endfunction

  // merge byte lanes 0 and 1 into a 16-bit value
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic              load_pending_reg, load_pending_next;
  logic [15:0]       temp_offset_reg,  temp_offset_next;
  logic [15:0]       current_gain_reg, current_gain_next;
  logic [15:0]       voltage_gain_reg, voltage_gain_next;
  logic [15:0]       temp_gain_reg,    temp_gain_next;
  logic [15:0]       result_reg,       result_next;
  logic              aw_full_reg,      aw_full_next;
  logic [31:0]       aw_addr_reg,      aw_addr_next;
  logic              w_full_reg,       w_full_next;
  logic [31:0]       w_data_reg,       w_data_next;
  logic [3:0]        w_strb_reg,       w_strb_next;
  logic              awready_reg,      awready_next;
  logic              wready_reg,       wready_next;
  logic              bvalid_reg,       bvalid_next;
  logic [1:0]        bresp_reg,        bresp_next;
  logic              arready_reg,      arready_next;
  logic              rvalid_reg,       rvalid_next;
  logic [31:0]       rdata_reg,        rdata_next;
  logic [1:0]        rresp_reg,        rresp_next;
  logic              wr_commit;
  reg_sel_type       wr_sel;
  reg_sel_type       rd_sel;

  // ----------------------------------------
  // coefficient and result registers
  // ----------------------------------------
  // factory load one edge after reset release, then software writes
  always_comb begin
    wr_sel            = decode(aw_addr_reg);
    wr_commit         = aw_full_reg && w_full_reg && !bvalid_reg;
    load_pending_next = 1'b0;
    temp_offset_next  = temp_offset_reg;
    current_gain_next = current_gain_reg;
    voltage_gain_next = voltage_gain_reg;
    temp_gain_next    = temp_gain_reg;
    result_next       = result_reg;
    if (load_pending_reg) begin
      temp_offset_next  = factory_temp_offset_i;
      current_gain_next = factory_current_gain_i;
      voltage_gain_next = factory_voltage_gain_i;
      temp_gain_next    = factory_temp_gain_i;
    end else if (wr_commit) begin
      case (wr_sel)
        SEL_TEMP_OFFSET:  temp_offset_next  = merge(temp_offset_reg, w_data_reg, w_strb_reg);
        SEL_CURRENT_GAIN: current_gain_next = merge(current_gain_reg, w_data_reg, w_strb_reg);
        SEL_VOLTAGE_GAIN: voltage_gain_next = merge(voltage_gain_reg, w_data_reg, w_strb_reg);
        SEL_TEMP_GAIN:    temp_gain_next    = merge(temp_gain_reg, w_data_reg, w_strb_reg);
        default:          ;
      endcase
    end
    // converter result capture, not writable from the bus
    if (vt_result_valid_i) begin
      result_next = vt_result_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_pending_reg <= 1'b1;
      temp_offset_reg  <= COEFF_PRE_LOAD;
      current_gain_reg <= COEFF_PRE_LOAD;
      voltage_gain_reg <= COEFF_PRE_LOAD;
      temp_gain_reg    <= COEFF_PRE_LOAD;
      result_reg       <= RESULT_RESET;
    end else begin
      load_pending_reg <= load_pending_next;
      temp_offset_reg  <= temp_offset_next;
      current_gain_reg <= current_gain_next;
      voltage_gain_reg <= voltage_gain_next;
      temp_gain_reg    <= temp_gain_next;
      result_reg       <= result_next;
    end
  end

  // coefficients leave straight from flops; datapath samples per result
  assign temp_offset_coeff_o  = temp_offset_reg;
  assign current_gain_coeff_o = current_gain_reg;
  assign voltage_gain_coeff_o = voltage_gain_reg;
  assign temp_gain_coeff_o    = temp_gain_reg;

  // ----------------------------------------
  // axi4-lite write and read channels
  // ----------------------------------------
  // address and data caught in either order, response after both
  always_comb begin
    rd_sel       = decode(s_axi_araddr_i);
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (s_axi_awvalid_i && awready_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_reg) begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata_i;
      w_strb_next = s_axi_wstrb_i;
    end
    if (wr_commit) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      // result register and holes refuse writes
      bresp_next   = (wr_sel == SEL_NONE || wr_sel == SEL_RESULT) ? RESP_SLVERR
                                                                   : RESP_OKAY;
    end else if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_full_next && !bvalid_next && !load_pending_next;
    wready_next  = !w_full_next && !bvalid_next && !load_pending_next;
    if (s_axi_arvalid_i && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      rresp_next   = RESP_OKAY;
      case (rd_sel)
        SEL_RESULT:       rdata_next = {16'h0000, result_reg};
        SEL_TEMP_OFFSET:  rdata_next = {16'h0000, temp_offset_reg};
        SEL_CURRENT_GAIN: rdata_next = {16'h0000, current_gain_reg};
        SEL_VOLTAGE_GAIN: rdata_next = {16'h0000, voltage_gain_reg};
        SEL_TEMP_GAIN:    rdata_next = {16'h0000, temp_gain_reg};
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next  = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 32'h00000000;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence full_write_to(reg_sel_type sel);
    wr_commit && wr_sel == sel && w_strb_reg[1:0] == 2'h3;
  endsequence

  chk_offset_write: assert property (
    full_write_to(SEL_TEMP_OFFSET) |=> temp_offset_coeff_o == 16'($past(w_data_reg)))
    else $error("offset coefficient not written");
  chk_cur_gain_write: assert property (
    full_write_to(SEL_CURRENT_GAIN) |=> current_gain_coeff_o == 16'($past(w_data_reg)))
    else $error("current gain not written");
  chk_volt_gain_write: assert property (
    full_write_to(SEL_VOLTAGE_GAIN) |=> voltage_gain_coeff_o == 16'($past(w_data_reg)))
    else $error("voltage gain not written");
  chk_temp_gain_write: assert property (
    full_write_to(SEL_TEMP_GAIN) |=> temp_gain_coeff_o == 16'($past(w_data_reg))
    && bvalid_reg && bresp_reg == RESP_OKAY)
    else $error("temperature gain not written");
  chk_factory_load: assert property (
    $fell(load_pending_reg) |-> temp_gain_coeff_o == $past(factory_temp_gain_i)
    && temp_offset_coeff_o == $past(factory_temp_offset_i))
    else $error("factory values not loaded");
  chk_result_capture: assert property (
    vt_result_valid_i |=> result_reg == $past(vt_result_i))
    else $error("conversion result not captured");
  chk_result_readonly: assert property (
    wr_commit && wr_sel == SEL_RESULT && !vt_result_valid_i
    |=> bresp_reg == RESP_SLVERR && $stable(result_reg))
    else $error("result register accepted a write");
  chk_coeff_hold: assert property (
    !wr_commit && !load_pending_reg
    |=> $stable(temp_offset_coeff_o) && $stable(current_gain_coeff_o)
    && $stable(voltage_gain_coeff_o) && $stable(temp_gain_coeff_o))
    else $error("coefficient changed without a write");

endmodule
`default_nettype wire

// ### core/cal_coeff_pkg.sv
// constants and types shared by the calibration coefficient bank
package cal_coeff_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [31:0] VOLTAGE_TEMP_RESULT_ADDR = 32'hffff0524;
  localparam logic [31:0] TEMP_OFFSET_COEFF_ADDR   = 32'hffff0538;
  localparam logic [31:0] CURRENT_GAIN_COEFF_ADDR  = 32'hffff053c;
  localparam logic [31:0] VOLTAGE_GAIN_COEFF_ADDR  = 32'hffff0540;
  localparam logic [31:0] TEMP_GAIN_COEFF_ADDR     = 32'hffff0544;

  // ----------------------------------------
  // field layout, reset values, responses
  // ----------------------------------------
  localparam int          COEFF_W          = 16;
  localparam logic [15:0] RESULT_RESET     = 16'h0000;
  localparam logic [15:0] COEFF_PRE_LOAD   = 16'h0000;  // held only until factory load
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_RESULT,
    SEL_TEMP_OFFSET,
    SEL_CURRENT_GAIN,
    SEL_VOLTAGE_GAIN,
    SEL_TEMP_GAIN
  } reg_sel_type;

endpackage

// ### verification/adc_calibration_coeffs_test.sv
// self-checking testbench for the calibration coefficient bank
`timescale 1ns/10ps
`default_nettype none
module adc_calibration_coeffs_test;
  import cal_coeff_pkg::*;
  `define CHK(got, want) begin checks_done++; if ((got) !== (want)) begin n_fail++; \
    $display("mismatch at %0t: got %h want %h", $time, got, want); end end
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [15:0] fac [4];
  logic        vt_valid = 1'b0;
  logic [15:0] vt_data = 16'h0000;
  logic [15:0] coeff_o [4];
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [15:0] m [4];        // model of the coefficient registers
  logic [15:0] m_res;        // model of the result register
  logic [31:0] addr_tab [4] = '{TEMP_OFFSET_COEFF_ADDR, CURRENT_GAIN_COEFF_ADDR,
                                VOLTAGE_GAIN_COEFF_ADDR, TEMP_GAIN_COEFF_ADDR};
  int          n_fail = 0;
  int          checks_done = 0;
  logic [1:0]  resp;
  logic [31:0] d;
  logic [3:0]  s;
  // ----------------------------------------
  // clock and device under test
  // ----------------------------------------
  always #5 clk_sys_i = ~clk_sys_i;
  cal_coeff_bank cal_coeff_bank_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .factory_temp_offset_i(fac[0]), .factory_current_gain_i(fac[1]),
    .factory_voltage_gain_i(fac[2]), .factory_temp_gain_i(fac[3]),
    .vt_result_valid_i(vt_valid), .vt_result_i(vt_data),
    .temp_offset_coeff_o(coeff_o[0]), .current_gain_coeff_o(coeff_o[1]),
    .voltage_gain_coeff_o(coeff_o[2]), .temp_gain_coeff_o(coeff_o[3]),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  // ----------------------------------------
  // closing report and bus tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic timed_out();
    n_fail++;
    $display("mismatch at %0t: handshake timeout", $time);
    wrap_up();
  endtask
  // write one word, both channels offered together
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] dv, input logic [3:0] sv,
                        output logic [1:0] r);
    int n;
    bit aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys_i);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= dv;
    wstrb   <= sv;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; !(aw_done && w_done); n++) begin
      @(posedge clk_sys_i);
      if (n > 50) timed_out();
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    for (n = 0; n <= 50; n++) begin
      if (bvalid) break;
      @(posedge clk_sys_i);
    end
    if (n > 50) timed_out();
    r = bresp;
    bready <= 1'b0;
  endtask
  // read one word and compare with the expected data and response
  task automatic axi_rd(input logic [31:0] a, input logic [31:0] want, input logic [1:0] wr);
    int n;
    @(posedge clk_sys_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n <= 50; n++) begin
      @(posedge clk_sys_i);
      if (arready) break;
    end
    if (n > 50) timed_out();
    arvalid <= 1'b0;
    for (n = 0; n <= 50; n++) begin
      @(posedge clk_sys_i);
      if (rvalid) break;
    end
    if (n > 50) timed_out();
    `CHK(rdata, want)
    `CHK(rresp, wr)
    rready <= 1'b0;
  endtask
  // reset with fresh factory trims, check pre-load and load
  task automatic do_reset();
    for (int i = 0; i < 4; i++) fac[i] <= 16'($urandom);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    for (int i = 0; i < 4; i++) `CHK(coeff_o[i], COEFF_PRE_LOAD)
    rst_n_i <= 1'b1;
    m_res = RESULT_RESET;
    repeat (2) @(posedge clk_sys_i);
    for (int i = 0; i < 4; i++) begin
      m[i] = fac[i];
      `CHK(coeff_o[i], m[i])
      axi_rd(addr_tab[i], {16'h0000, m[i]}, RESP_OKAY);
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(84));
    do_reset();
    axi_rd(VOLTAGE_TEMP_RESULT_ADDR, {16'h0000, RESULT_RESET}, RESP_OKAY);
    // every coefficient, each nonzero lane 0/1 strobe pattern, back to back
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) begin
        d = $urandom;
        s = (k == 0) ? 4'hf : 4'(k);
        axi_wr(addr_tab[i], d, s, resp);
        if (s[0]) m[i][7:0] = d[7:0];
        if (s[1]) m[i][15:8] = d[15:8];
        `CHK(resp, RESP_OKAY)
        `CHK(coeff_o[i], m[i])
      end
      for (int i = 0; i < 4; i++) axi_rd(addr_tab[i], {16'h0000, m[i]}, RESP_OKAY);
    end
    // calibration flow: result pulse, read it, copy into a coefficient
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      vt_data <= 16'($urandom);
      vt_valid <= 1'b1;
      @(posedge clk_sys_i);
      vt_valid <= 1'b0;
      m_res = vt_data;
      axi_rd(VOLTAGE_TEMP_RESULT_ADDR, {16'h0000, m_res}, RESP_OKAY);
      axi_wr(addr_tab[i], {16'hffff, m_res}, 4'hf, resp);
      m[i] = m_res;
      `CHK(coeff_o[i], m[i])
    end
    // read-only result and unmapped places are refused without change
    axi_wr(VOLTAGE_TEMP_RESULT_ADDR, ~{16'h0000, m_res}, 4'hf, resp);
    `CHK(resp, RESP_SLVERR)
    axi_rd(VOLTAGE_TEMP_RESULT_ADDR, {16'h0000, m_res}, RESP_OKAY);
    axi_wr(32'hffff0530, $urandom, 4'hf, resp);
    `CHK(resp, RESP_SLVERR)
    axi_wr(32'hffff0548, $urandom, 4'hf, resp);
    `CHK(resp, RESP_SLVERR)
    axi_rd(32'hffff0530, 32'h00000000, RESP_SLVERR);
    for (int i = 0; i < 4; i++) `CHK(coeff_o[i], m[i])
    // second reset in mid-run reloads the factory trims
    do_reset();
    axi_rd(VOLTAGE_TEMP_RESULT_ADDR, {16'h0000, RESULT_RESET}, RESP_OKAY);
    wrap_up();
  end
endmodule
`default_nettype wire
